/* hw/eeprom_slave_pkg.sv */
// Constants, timing figures and state encoding for the two-wire memory
// slave write path.
// Assumes a 250 MHz system clock and a bus master that drives the clock.
//
// Behaviour
// [RULE1] Master waits the power-up delay before any read or write.
// [RULE2] During the program cycle the slave releases the data line and ignores its address.
// [RULE3] Data falling while clock is high is a start; nothing happens before one.
// [RULE4] Data rising while clock is high is a stop; every operation ends with one.
// [RULE5] Data changes only while clock is low; changes while high are start or stop.
// [RULE6] Master begins a transfer only on an idle bus.
// [RULE7] Slave acknowledges a first byte whose upper bits match 1010, low three ignored.
// [RULE8] Address byte bit zero picks direction: one reads, zero writes.
// [RULE9] Receiver acknowledges each byte by holding data low in the ninth clock.
// [RULE10] Once addressed for write, every later received byte is acknowledged except data bytes under protect.
// [RULE11] Read sends eight bits, releases, samples acknowledge, stops without one.
// [RULE12] Byte write is start, address, two address bytes, one data byte, stop.
// [RULE13] A stop ending a write starts the self-timed program cycle.
// [RULE14] Up to 64 data bytes are taken and committed in one program cycle.
// [RULE15] After each data byte only the six low address bits advance.
// [RULE16] Beyond 64 bytes the in-page address wraps and overwrites earlier bytes.
// [RULE17] Polling: address is refused while programming and acknowledged after.
// [RULE18] Writes are allowed with protect low and all blocked with protect high.
// [RULE19] The master makes the clock and all starts and stops.
// [RULE20] The data line is only pulled low or released, never driven high.
// [RULE21] Under protect, addresses are acknowledged but the first data byte is not.
// [RULE22] Memory address is fourteen bits; top two bits of first byte ignored.

package eeprom_slave_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int POWERUP_TO_READ_DELAY_MS = 1;
  localparam int POWERUP_TO_WRITE_DELAY_MS = 1;
  localparam int PROGRAM_MS = 10;
  localparam int POWERUP_MS = (POWERUP_TO_READ_DELAY_MS >
                               POWERUP_TO_WRITE_DELAY_MS) ?
                              POWERUP_TO_READ_DELAY_MS :
                              POWERUP_TO_WRITE_DELAY_MS;
  localparam int PU_CYCLES = POWERUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WR_CYCLES = PROGRAM_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 22;

  localparam int ADDR_W = 14;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic LINE_IDLE = 1'h1;

  typedef enum logic [2:0] {
    st_idle,
    st_dev_addr,
    st_addr_hi,
    st_addr_lo,
    st_data,
    st_read,
    st_wait_stop
  } state_t;

endpackage

/* hw/link_bit_if.sv */
// Carries each sampled bus bit from the serial clock domain to the core.
// Assumes the receiving side synchronises both signals before use.
`timescale 1ns/1ps
interface link_bit_if;
  logic bit_tog;
  logic bit_val;
  modport link (output bit_tog, output bit_val);
  modport core (input bit_tog, input bit_val);
endinterface

/* hw/link_capture.sv */
// Samples the data line on each rising serial clock edge.
// Assumes the serial clock stops between frames; the toggle only announces
// edges that really happened, so no edge after the last is relied upon.
`timescale 1ns/1ps
module link_capture (
  input wire logic i_scl_clk,
  input wire logic i_sda,
  link_bit_if.link lnk
);
  // The serial clock may never run while reset is high, so these flops
  // start from a power-on value instead of the system reset.
  logic tog_reg = 1'h0;
  logic val_reg = 1'h1;

  always_ff @(posedge i_scl_clk) begin
    val_reg <= i_sda;
    tog_reg <= ~tog_reg;
  end

  assign lnk.bit_tog = tog_reg;
  assign lnk.bit_val = val_reg;
endmodule

/* hw/busy_timer.sv */
// Down-counter that holds a busy level for a fixed number of cycles.
// Assumes a synchronous active-high reset on the system clock.
`timescale 1ns/1ps
module busy_timer #(
  parameter int CYCLES = 4,
  parameter bit BUSY_AT_RESET = 1'b0,
  parameter int CNT_W = 22
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_busy
);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] RST_LOAD = BUSY_AT_RESET ? LOAD : '0;

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_reg <= RST_LOAD;
      o_busy <= BUSY_AT_RESET;
    end else if (i_start) begin
      cnt_reg <= LOAD;
      o_busy <= 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      o_busy <= 1'b0;
    end
  end
endmodule

/* hw/eeprom_write_slave.sv */
// Two-wire bus slave front end of a byte-wide nonvolatile memory: start and
// stop detection, address match, acknowledge, page buffer and program
// sequencing. The storage array itself sits outside this block.
// Assumes the array returns read data for o_nv_rd_addr within a few system
// cycles and accepts one byte per cycle while o_nv_we is high.
`timescale 1ns/1ps
module eeprom_write_slave #(
  parameter int PU_CYCLES = eeprom_slave_pkg::PU_CYCLES,
  parameter int WR_CYCLES = eeprom_slave_pkg::WR_CYCLES,
  parameter int CNT_W = eeprom_slave_pkg::TIMER_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl_clk,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic [7:0] i_nv_rd_data,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_busy,
  output logic o_nv_we,
  output logic [eeprom_slave_pkg::ADDR_W-1:0] o_nv_wr_addr,
  output logic [7:0] o_nv_wr_data,
  output logic [eeprom_slave_pkg::ADDR_W-1:0] o_nv_rd_addr
);

  localparam int AW = eeprom_slave_pkg::ADDR_W;
  localparam int PW = eeprom_slave_pkg::PAGE_W;

  // Receive states are those in which the slave answers bytes itself.
  function automatic logic is_rx(input eeprom_slave_pkg::state_t st);
    return st == eeprom_slave_pkg::st_dev_addr ||
           st == eeprom_slave_pkg::st_addr_hi ||
           st == eeprom_slave_pkg::st_addr_lo ||
           st == eeprom_slave_pkg::st_data;
  endfunction

  function automatic logic ack_decide(input eeprom_slave_pkg::state_t st,
                                      input logic [7:0] byte_in,
                                      input logic protect);
    unique case (st)
      eeprom_slave_pkg::st_dev_addr:
        ack_decide = byte_in[7:4] == eeprom_slave_pkg::DEV_CODE;
      eeprom_slave_pkg::st_addr_hi,
      eeprom_slave_pkg::st_addr_lo:
        ack_decide = 1'b1;
      eeprom_slave_pkg::st_data:
        ack_decide = !protect; // [RULE18] [RULE21]
      default:
        ack_decide = 1'b0;
    endcase
  endfunction

  link_bit_if lnk ();

  link_capture u_link (
    .i_scl_clk(i_scl_clk),
    .i_sda(i_sda),
    .lnk(lnk.link)
  );

  // Synchronisers: index 0 is the first flop, read only by index 1.
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] wp_sync_reg;
  logic [1:0] tog_sync_reg;
  logic [1:0] val_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic tog_prev_reg;
  logic tog_old_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_sync_reg <= {2{eeprom_slave_pkg::LINE_IDLE}};
      sda_sync_reg <= {2{eeprom_slave_pkg::LINE_IDLE}};
      wp_sync_reg <= 2'h0;
      tog_sync_reg <= 2'h0;
      val_sync_reg <= {2{eeprom_slave_pkg::LINE_IDLE}};
      scl_prev_reg <= eeprom_slave_pkg::LINE_IDLE;
      sda_prev_reg <= eeprom_slave_pkg::LINE_IDLE;
      tog_prev_reg <= 1'h0;
      tog_old_reg <= 1'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl_clk};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      wp_sync_reg <= {wp_sync_reg[0], i_wp};
      tog_sync_reg <= {tog_sync_reg[0], lnk.bit_tog};
      val_sync_reg <= {val_sync_reg[0], lnk.bit_val};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
      tog_prev_reg <= tog_sync_reg[1];
      tog_old_reg <= tog_prev_reg;
    end
  end

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic bit_ev;
  logic bit_val;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic pu_busy;
  logic wr_busy;
  logic bus_off;
  logic slot_ev;
  logic data_take;
  logic prog_go;

  eeprom_slave_pkg::state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic ack_reg;
  logic [7:0] tx_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-PW-1:0] page_reg;
  logic [eeprom_slave_pkg::PAGE_BYTES-1:0] fill_reg;
  logic [7:0] page_mem [eeprom_slave_pkg::PAGE_BYTES];
  logic copy_active_reg;
  logic [PW-1:0] copy_idx_reg;
  logic [7:0] byte_in;

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign wp_s = wp_sync_reg[1];
  assign bit_val = val_sync_reg[1];
  // The bit is taken one cycle after its toggle has settled, so a data
  // synchroniser that resolved a cycle late has still caught up.
  assign bit_ev = tog_prev_reg ^ tog_old_reg;
  assign scl_fall = scl_prev_reg & ~scl_s;
  // Any data edge with the clock held high is framing, never data.
  assign start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // [RULE3] [RULE5]
  assign stop_ev = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // [RULE4] [RULE5]
  // Power-up hold and the program cycle both switch the bus front end off.
  assign bus_off = pu_busy | wr_busy; // [RULE1] [RULE2] [RULE17]
  assign byte_in = {shift_reg[6:0], bit_val};
  assign slot_ev = !bus_off && !start_ev && !stop_ev && bit_ev &&
                   cnt_reg == eeprom_slave_pkg::ACK_SLOT;
  assign data_take = slot_ev && state_reg == eeprom_slave_pkg::st_data &&
                     ack_reg;
  assign prog_go = stop_ev && !bus_off && fill_reg != '0 &&
                   !copy_active_reg; // [RULE13]

  busy_timer #(
    .CYCLES(PU_CYCLES),
    .BUSY_AT_RESET(1'b1),
    .CNT_W(CNT_W)
  ) u_pu_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(1'b0),
    .o_busy(pu_busy)
  );

  busy_timer #(
    .CYCLES(WR_CYCLES),
    .BUSY_AT_RESET(1'b0),
    .CNT_W(CNT_W)
  ) u_wr_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(prog_go),
    .o_busy(wr_busy)
  );

  // Byte framing and protocol state.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || bus_off) begin
      state_reg <= eeprom_slave_pkg::st_idle; // [RULE2]
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg <= eeprom_slave_pkg::st_dev_addr; // [RULE3]
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= eeprom_slave_pkg::st_idle; // [RULE4]
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (bit_ev && state_reg != eeprom_slave_pkg::st_idle &&
                 state_reg != eeprom_slave_pkg::st_wait_stop) begin
      if (cnt_reg != eeprom_slave_pkg::ACK_SLOT) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == eeprom_slave_pkg::LAST_DATA_BIT) begin
          ack_reg <= ack_decide(state_reg, byte_in, wp_s); // [RULE7] [RULE10] [RULE21]
        end
      end else begin
        cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        unique case (state_reg)
          eeprom_slave_pkg::st_dev_addr: begin
            if (!ack_reg) begin
              state_reg <= eeprom_slave_pkg::st_wait_stop;
            end else if (shift_reg[0]) begin
              state_reg <= eeprom_slave_pkg::st_read; // [RULE8]
            end else begin
              state_reg <= eeprom_slave_pkg::st_addr_hi; // [RULE8]
            end
          end
          eeprom_slave_pkg::st_addr_hi: begin
            state_reg <= eeprom_slave_pkg::st_addr_lo;
          end
          eeprom_slave_pkg::st_addr_lo: begin
            state_reg <= eeprom_slave_pkg::st_data;
          end
          eeprom_slave_pkg::st_data: begin
            if (!ack_reg) begin
              state_reg <= eeprom_slave_pkg::st_wait_stop; // [RULE21]
            end
          end
          eeprom_slave_pkg::st_read: begin
            if (bit_val) begin
              state_reg <= eeprom_slave_pkg::st_wait_stop; // [RULE11]
            end
          end
          default: begin
            state_reg <= eeprom_slave_pkg::st_idle;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      shift_reg <= 8'h00;
    end else if (bit_ev && cnt_reg != eeprom_slave_pkg::ACK_SLOT) begin
      shift_reg <= byte_in;
    end
  end

  // Address pointer and transmit byte; the read path fetches and then
  // advances, so the pointer always names the next byte to send.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      addr_reg <= '0;
      page_reg <= '0;
      tx_reg <= 8'h00;
    end else if (slot_ev) begin
      unique case (state_reg)
        eeprom_slave_pkg::st_dev_addr: begin
          if (ack_reg && shift_reg[0]) begin
            tx_reg <= i_nv_rd_data;
            addr_reg <= addr_reg + 1'b1;
          end
        end
        eeprom_slave_pkg::st_addr_hi: begin
          addr_reg[AW-1:8] <= shift_reg[AW-9:0]; // [RULE22]
        end
        eeprom_slave_pkg::st_addr_lo: begin
          addr_reg[7:0] <= shift_reg;
          page_reg <= {addr_reg[AW-1:8], shift_reg[7:PW]};
        end
        eeprom_slave_pkg::st_data: begin
          if (ack_reg) begin
            addr_reg[PW-1:0] <= addr_reg[PW-1:0] + 1'b1; // [RULE15] [RULE16]
          end
        end
        eeprom_slave_pkg::st_read: begin
          if (!bit_val) begin
            tx_reg <= i_nv_rd_data; // [RULE11]
            addr_reg <= addr_reg + 1'b1;
          end
        end
        default: begin
          tx_reg <= tx_reg;
        end
      endcase
    end
  end

  // Page buffer; a later byte at the same in-page slot simply replaces it.
  always_ff @(posedge i_sys_clk) begin
    if (data_take) begin
      page_mem[addr_reg[PW-1:0]] <= shift_reg; // [RULE14] [RULE16]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fill_reg <= '0;
    end else if (copy_active_reg && copy_idx_reg == '1) begin
      fill_reg <= '0;
    end else if (slot_ev && state_reg == eeprom_slave_pkg::st_addr_lo) begin
      fill_reg <= '0;
    end else if (data_take) begin
      fill_reg[addr_reg[PW-1:0]] <= 1'b1; // [RULE18]
    end
  end

  // The whole page is walked once; only filled slots are written, so a
  // byte write touches one location. The walk is far shorter than the
  // program time.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      copy_active_reg <= 1'b0;
      copy_idx_reg <= '0;
      o_nv_we <= 1'b0;
      o_nv_wr_addr <= '0;
      o_nv_wr_data <= 8'h00;
    end else begin
      o_nv_we <= copy_active_reg && fill_reg[copy_idx_reg]; // [RULE14]
      o_nv_wr_addr <= {page_reg, copy_idx_reg};
      o_nv_wr_data <= page_mem[copy_idx_reg];
      if (prog_go) begin
        copy_active_reg <= 1'b1; // [RULE13]
        copy_idx_reg <= '0;
      end else if (copy_active_reg) begin
        copy_idx_reg <= copy_idx_reg + 1'b1;
        if (copy_idx_reg == '1) begin
          copy_active_reg <= 1'b0;
        end
      end
    end
  end

  // Data line: changes only after the clock has gone low, and the pin is
  // only ever pulled low, so a high bit is just a released line.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || bus_off) begin
      o_sda_oe <= 1'b0; // [RULE2]
    end else if (scl_fall) begin
      if (state_reg == eeprom_slave_pkg::st_read) begin
        o_sda_oe <= cnt_reg != eeprom_slave_pkg::ACK_SLOT &&
                    !tx_reg[3'h7 - cnt_reg[2:0]]; // [RULE11] [RULE5]
      end else begin
        o_sda_oe <= is_rx(state_reg) && ack_reg &&
                    cnt_reg == eeprom_slave_pkg::ACK_SLOT; // [RULE9] [RULE10]
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
      o_busy <= 1'b1;
      o_nv_rd_addr <= '0;
    end else begin
      o_sda_out <= 1'b0; // [RULE20]
      o_busy <= bus_off;
      o_nv_rd_addr <= addr_reg;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence dev_byte_acked;
    slot_ev && state_reg == eeprom_slave_pkg::st_dev_addr && ack_reg;
  endsequence

  sequence stop_with_data;
    stop_ev && !bus_off && fill_reg != '0 && !copy_active_reg;
  endsequence

  sda_low_only_a: assert property (o_sda_out == 1'b0) // [RULE20]
    else $error("data line driven high");
  busy_release_a: assert property (bus_off |=> !o_sda_oe && // [RULE2]
      state_reg == eeprom_slave_pkg::st_idle)
    else $error("bus not released while busy");
  idle_wait_a: assert property ( // [RULE3]
      state_reg == eeprom_slave_pkg::st_idle && !start_ev |=>
      state_reg == eeprom_slave_pkg::st_idle)
    else $error("left idle without a start");
  start_frame_a: assert property (start_ev && !bus_off |=> // [RULE3]
      state_reg == eeprom_slave_pkg::st_dev_addr && cnt_reg == 4'h0)
    else $error("start not framed");
  stop_idle_a: assert property (stop_ev |=> // [RULE4]
      state_reg == eeprom_slave_pkg::st_idle)
    else $error("stop did not end operation");
  addr_match_a: assert property (dev_byte_acked |-> // [RULE7]
      shift_reg[7:4] == eeprom_slave_pkg::DEV_CODE)
    else $error("acknowledged a foreign address");
  dir_select_a: assert property (dev_byte_acked |=> // [RULE8]
      state_reg == ($past(shift_reg[0]) ? eeprom_slave_pkg::st_read :
                    eeprom_slave_pkg::st_addr_hi))
    else $error("wrong direction taken");
  ack_drive_a: assert property (scl_fall && !bus_off && ack_reg && // [RULE9]
      is_rx(state_reg) && cnt_reg == eeprom_slave_pkg::ACK_SLOT |=>
      o_sda_oe [*2])
    else $error("acknowledge not driven");
  page_wrap_a: assert property (data_take |=> // [RULE15]
      addr_reg[PW-1:0] == $past(addr_reg[PW-1:0]) + 1'b1 &&
      addr_reg[AW-1:PW] == $past(addr_reg[AW-1:PW]))
    else $error("page address step wrong");
  protect_nack_a: assert property (wp_s && bit_ev && !bus_off && // [RULE21]
      !start_ev && !stop_ev && state_reg == eeprom_slave_pkg::st_data &&
      cnt_reg == eeprom_slave_pkg::LAST_DATA_BIT |=> !ack_reg)
    else $error("protected data byte acknowledged");
  prog_start_a: assert property (stop_with_data |=> // [RULE13]
      wr_busy && copy_active_reg)
    else $error("program cycle not started");
  page_commit_a: assert property (stop_with_data |-> ##65 // [RULE14]
      !copy_active_reg && fill_reg == '0)
    else $error("page commit length wrong");
  read_release_a: assert property (scl_fall && !bus_off && // [RULE11]
      state_reg == eeprom_slave_pkg::st_read &&
      cnt_reg == eeprom_slave_pkg::ACK_SLOT |=> !o_sda_oe)
    else $error("line held in master acknowledge slot");

endmodule

/* verification/i2c_master_model.sv */
// Behavioural two-wire bus master that makes the serial clock and data.
// Assumes a pull-up on the data line; the clock idles high between frames.
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_pull
);
  localparam realtime Q = 31.25;
  initial begin
    o_scl = 1'h1;
    o_pull = 1'h0;
  end
  // Works from idle and as a repeated start; data moves only with clock low.
  task automatic start();
    o_pull = 1'h0;
    #Q o_scl = 1'h1;
    #Q o_pull = 1'h1;
    #Q o_scl = 1'h0;
  endtask
  // The trailing idle time keeps the bus free before the next start.
  task automatic stop();
    #Q o_pull = 1'h1;
    #Q o_scl = 1'h1;
    #Q o_pull = 1'h0;
    #(4*Q);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    #Q o_pull = ~b;
    #Q o_scl = 1'h1;
    #Q r = i_sda;
    #Q o_scl = 1'h0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'h1, r);
    ack = ~r;
  endtask
  // Master acknowledges to continue a read, or not, to end it.
  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'h1, r);
      d[i] = r;
    end
    xfer_bit(~ack_it, r);
  endtask
endmodule

/* verification/eeprom_write_slave_tb.sv */
// Self-checking bench for the two-wire memory slave write path.
// Assumes shortened power-up and program counts; the bench models the array.
`timescale 1ns/1ps
module eeprom_write_slave_tb;
  localparam int PU = 200;
  localparam int WR = 1000;
  logic clk, rst, wp, scl, pull, sda, sda_out, sda_oe, busy, we;
  logic [13:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data;
  logic [7:0] mem [0:16383];
  logic [21:0] wq [$];
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign sda = ~(sda_oe | pull);
  assign rd_data = mem[rd_addr];
  eeprom_write_slave #(.PU_CYCLES(PU), .WR_CYCLES(WR)) DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_scl_clk(scl), .i_sda(sda),
    .i_wp(wp), .i_nv_rd_data(rd_data), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_busy(busy), .o_nv_we(we),
    .o_nv_wr_addr(wr_addr), .o_nv_wr_data(wr_data),
    .o_nv_rd_addr(rd_addr));
  i2c_master_model m (.i_sda(sda), .o_scl(scl), .o_pull(pull));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [21:0] g, input logic [21:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_val({21'h0, g}, {21'h0, e});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  // Registered outputs are taken at the falling edge, once settled.
  always @(negedge clk) begin
    if (we === 1'h1) begin
      wq.push_back({wr_addr, wr_data});
      mem[wr_addr] = wr_data;
    end
    if (sda_oe === 1'h1) chk_bit(sda_out, 1'h0);
  end
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk_bit(busy, v);
  endtask
  task automatic head(input logic [7:0] dev, input logic [7:0] hi,
                      input logic [7:0] lo);
    logic ack;
    m.start();
    m.send_byte(dev, ack);
    chk_bit(ack, 1'h1);
    m.send_byte(hi, ack);
    chk_bit(ack, 1'h1);
    m.send_byte(lo, ack);
    chk_bit(ack, 1'h1);
  endtask
  // The start lands inside the power-up hold, so nothing may answer.
  task automatic t_powerup();
    logic ack;
    m.start();
    m.send_byte(8'hA0, ack);
    chk_bit(ack, 1'h0);
    m.stop();
    wait_busy(1'h0, PU + 50);
  endtask
  task automatic t_bad_addr();
    logic ack;
    m.start();
    m.send_byte(8'h90, ack);
    chk_bit(ack, 1'h0);
    m.start();
    m.send_byte(8'hB0, ack);
    chk_bit(ack, 1'h0);
    m.stop();
  endtask
  // Top two address bits are set here and must be dropped.
  task automatic t_byte_write();
    logic ack;
    wq.delete();
    head(8'hAE, 8'hFF, 8'h05);
    m.send_byte(8'h5A, ack);
    chk_bit(ack, 1'h1);
    m.stop();
    wait_busy(1'h1, 20);
    m.start();
    m.send_byte(8'hA0, ack);
    chk_bit(ack, 1'h0);
    m.stop();
    chk_val(22'(wq.size()), 22'h1);
    chk_val(wq[0], {14'h3F05, 8'h5A});
    wait_busy(1'h0, WR + 20);
    m.start();
    m.send_byte(8'hA0, ack);
    chk_bit(ack, 1'h1);
    m.stop();
  endtask
  // Starts two slots before the page end and sends two bytes too many.
  task automatic t_page_wrap();
    logic ack;
    logic [7:0] exp [0:63];
    wq.delete();
    head(8'hA2, 8'h00, 8'h7E);
    for (int k = 0; k < 66; k++) begin
      m.send_byte(8'h10 + k[7:0], ack);
      chk_bit(ack, 1'h1);
      exp[(62 + k) % 64] = 8'h10 + k[7:0];
    end
    m.stop();
    wait_busy(1'h1, 20);
    repeat (70) @(negedge clk);
    chk_val(22'(wq.size()), 22'h40);
    for (int s = 0; s < 64 && s < wq.size(); s++) begin
      chk_val(wq[s], {8'h01, s[5:0], exp[s]});
    end
    wait_busy(1'h0, WR + 20);
  endtask
  task automatic t_protect();
    logic ack;
    @(negedge clk);
    wp = 1'h1;
    wq.delete();
    head(8'hA0, 8'h00, 8'h10);
    m.send_byte(8'h33, ack);
    chk_bit(ack, 1'h0);
    m.stop();
    repeat (70) @(negedge clk);
    chk_bit(busy, 1'h0);
    chk_val(22'(wq.size()), 22'h0);
    wp = 1'h0;
  endtask
  task automatic t_read();
    logic ack;
    logic [7:0] d;
    head(8'hA0, 8'h3F, 8'h05);
    m.start();
    m.send_byte(8'hA1, ack);
    chk_bit(ack, 1'h1);
    m.recv_byte(1'h1, d);
    chk_val({14'h0, d}, {14'h0, 8'h5A});
    m.recv_byte(1'h0, d);
    chk_val({14'h0, d}, {14'h0, 8'hC5});
    m.stop();
  endtask
  initial begin
    rst = 1'h1;
    wp = 1'h0;
    for (int i = 0; i < 16384; i++) begin
      mem[i] = i[7:0] ^ 8'hC3;
    end
    repeat (20) @(negedge clk);
    rst = 1'h0;
    t_powerup();
    t_bad_addr();
    t_byte_write();
    t_page_wrap();
    t_protect();
    t_read();
    finish_test();
  end
endmodule
